//--- hdl/wfc_top.sv
// Module: wake-up factor controller with APB register access
// ----------------------------------------------------------------
// Notes on behaviour
// R1 - Either system or power-up reset initialises the block and registers.
// R2 - Wake events end power save, managed in low, middle, high groups.
// R3 - Each group has a 32-bit factor register, one event per bit.
// R4 - Each group has a 32-bit mask register aligned with factor bits.
// R5 - Each group has a 32-bit clear register aligned with factor bits.
// R6 - Each event has one fixed position in factor, mask and clear.
// R7 - Bus receive inputs may wake from deep stop despite controllers off.
// R8 - Software uses external interrupt input for serial receive wake-up.
// R9 - Each event enabled separately; only enabled events end stand-by.
// R10 - Factor bit set on event, held until software writes one to clear.
// ----------------------------------------------------------------
//
// The APB interface to the registers and the register offsets were decided locally.
module wfc_top
    import wfc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic system_reset,
    input wire logic power_up_reset,
    input wire logic deep_stop_mode,
    input wire logic [31:0] wake_events_low,
    input wire logic [31:0] wake_events_mid,
    input wire logic [31:0] wake_events_high,
    input wire logic [WFC_BUS_RX_NUM-1:0] bus_receive_input,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic wake_request
);
    // ----------------------------------------------------------------
    // Reset combination and bus decode
    // ----------------------------------------------------------------
    logic rst_n;
    logic wr_acc;
    logic rd_acc;
    logic hit;
    logic [31:0] clr_low;
    logic [31:0] clr_mid;
    logic [31:0] clr_high;
    logic [31:0] ev_low;
    logic [31:0] flags_low;
    logic [31:0] flags_mid;
    logic [31:0] flags_high;
    logic [31:0] mask_low;
    logic [31:0] mask_mid;
    logic [31:0] mask_high;
    logic wake_low;
    logic wake_mid;
    logic wake_high;
    logic [31:0] rdata_nxt;

    // Either reset initialises everything: flags and wake request cleared, masks set to all ones
    assign rst_n = nrst && !system_reset && !power_up_reset; // see R1

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
        is_reg = (a == o);
    endfunction : is_reg

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign hit = is_reg(paddr, WFC_OFS_FLAGS_LOW)
        || is_reg(paddr, WFC_OFS_MASK_LOW)
        || is_reg(paddr, WFC_OFS_CLEAR_LOW)
        || is_reg(paddr, WFC_OFS_FLAGS_MID)
        || is_reg(paddr, WFC_OFS_MASK_MID)
        || is_reg(paddr, WFC_OFS_CLEAR_MID)
        || is_reg(paddr, WFC_OFS_FLAGS_HIGH)
        || is_reg(paddr, WFC_OFS_MASK_HIGH)
        || is_reg(paddr, WFC_OFS_CLEAR_HIGH)
        || is_reg(paddr, WFC_OFS_STATUS);

    // Clear registers are write-one pulses, they store nothing
    assign clr_low = (wr_acc && is_reg(paddr, WFC_OFS_CLEAR_LOW))
        ? pwdata : 32'h0000_0000; // see R5
    assign clr_mid = (wr_acc && is_reg(paddr, WFC_OFS_CLEAR_MID))
        ? pwdata : 32'h0000_0000; // see R5
    assign clr_high = (wr_acc && is_reg(paddr, WFC_OFS_CLEAR_HIGH))
        ? pwdata : 32'h0000_0000; // see R5

    // ----------------------------------------------------------------
    // Event routing
    // ----------------------------------------------------------------
    // Receive pins stay live while their controllers are powered down
    always_comb
    begin
        ev_low = wake_events_low;
        ev_low[WFC_BUS_RX_LSB +: WFC_BUS_RX_NUM] =
            wake_events_low[WFC_BUS_RX_LSB +: WFC_BUS_RX_NUM]
            | bus_receive_input; // see R7
    end

    // Serial receive has no bit; software arms the shared pin interrupt
    // instead. see R8

    // ----------------------------------------------------------------
    // Groups, fixed bit positions in all three registers
    // ----------------------------------------------------------------
    wfc_group #(.WIDTH(32)) u_low (
        .core_clk(core_clk),
        .nrst(rst_n),
        .event_in(ev_low),
        .clear_in(clr_low),
        .mask_we(wr_acc && is_reg(paddr, WFC_OFS_MASK_LOW)),
        .mask_wdata(pwdata),
        .flags_r(flags_low),
        .mask_r(mask_low),
        .wake_nxt(wake_low)
    ); // see R6

    wfc_group #(.WIDTH(32)) u_mid (
        .core_clk(core_clk),
        .nrst(rst_n),
        .event_in(wake_events_mid),
        .clear_in(clr_mid),
        .mask_we(wr_acc && is_reg(paddr, WFC_OFS_MASK_MID)),
        .mask_wdata(pwdata),
        .flags_r(flags_mid),
        .mask_r(mask_mid),
        .wake_nxt(wake_mid)
    ); // see R6

    wfc_group #(.WIDTH(32)) u_high (
        .core_clk(core_clk),
        .nrst(rst_n),
        .event_in(wake_events_high),
        .clear_in(clr_high),
        .mask_we(wr_acc && is_reg(paddr, WFC_OFS_MASK_HIGH)),
        .mask_wdata(pwdata),
        .flags_r(flags_high),
        .mask_r(mask_high),
        .wake_nxt(wake_high)
    ); // see R6

    // ----------------------------------------------------------------
    // Wake request
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            wake_request <= 1'b0;
        else
            wake_request <= wake_low || wake_mid || wake_high; // see R2
    end

    // ----------------------------------------------------------------
    // APB read path and response
    // ----------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            WFC_OFS_FLAGS_LOW: rdata_nxt = flags_low;
            WFC_OFS_MASK_LOW: rdata_nxt = mask_low;
            WFC_OFS_FLAGS_MID: rdata_nxt = flags_mid;
            WFC_OFS_MASK_MID: rdata_nxt = mask_mid;
            WFC_OFS_FLAGS_HIGH: rdata_nxt = flags_high;
            WFC_OFS_MASK_HIGH: rdata_nxt = mask_high;
            WFC_OFS_STATUS:
            begin
                rdata_nxt[WFC_STAT_WAKE_BIT] = wake_request;
                rdata_nxt[WFC_STAT_DEEP_BIT] = deep_stop_mode;
            end
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data captured in setup so it is stable through access
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (rd_acc)
            prdata <= rdata_nxt;
    end

    // Response one cycle into the access phase
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            pready <= 1'b0;
        else
            pready <= psel && !penable;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            pslverr <= 1'b0;
        else
            pslverr <= psel && !penable && !hit;
    end

    a_wake_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flags_low[0] && !mask_low[0]) |-> wake_request) // see R9
        else $error("unmasked factor did not raise wake request");
    a_mask_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(wake_request) |-> ((flags_low & ~mask_low) != 0)
        || ((flags_mid & ~mask_mid) != 0)
        || ((flags_high & ~mask_high) != 0)) // see R9
        else $error("wake request without enabled factor");
    a_rx_wake: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_receive_input[0] |=> flags_low[WFC_BUS_RX_LSB]) // see R7
        else $error("bus receive input not recorded");
    a_clear_low: assert property (@(posedge core_clk) disable iff (!rst_n)
        clr_low[5] && !ev_low[5] |=> !flags_low[5]) // see R10
        else $error("clear write left flag set");
    a_apb_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
        psel && !penable |=> pready) // local APB timing, no rule
        else $error("pready not one cycle after setup");

    c_wake: cover property (@(posedge core_clk) $rose(wake_request));
    c_clear: cover property (@(posedge core_clk) clr_mid != 0);
    c_rx: cover property (@(posedge core_clk) deep_stop_mode
        && bus_receive_input != 0);
endmodule : wfc_top

//--- hdl/wfc_pkg.sv
// Package: register map and constants of the wake-up factor controller
package wfc_pkg;
    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] WFC_OFS_FLAGS_LOW = 8'h00;
    localparam logic [7:0] WFC_OFS_MASK_LOW = 8'h04;
    localparam logic [7:0] WFC_OFS_CLEAR_LOW = 8'h08;
    localparam logic [7:0] WFC_OFS_FLAGS_MID = 8'h10;
    localparam logic [7:0] WFC_OFS_MASK_MID = 8'h14;
    localparam logic [7:0] WFC_OFS_CLEAR_MID = 8'h18;
    localparam logic [7:0] WFC_OFS_FLAGS_HIGH = 8'h20;
    localparam logic [7:0] WFC_OFS_MASK_HIGH = 8'h24;
    localparam logic [7:0] WFC_OFS_CLEAR_HIGH = 8'h28;
    localparam logic [7:0] WFC_OFS_STATUS = 8'h30;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] WFC_FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] WFC_MASK_RST = 32'hFFFF_FFFF;
    // ----------------------------------------------------------------
    // Group indices and status field positions
    // ----------------------------------------------------------------
    localparam int WFC_GRP_LOW = 0;
    localparam int WFC_GRP_MID = 1;
    localparam int WFC_GRP_HIGH = 2;
    localparam int WFC_NUM_GRP = 3;
    localparam int WFC_STAT_WAKE_BIT = 0;
    localparam int WFC_STAT_DEEP_BIT = 1;
    // Bus receive inputs sit in low group bits 23..28
    localparam int WFC_BUS_RX_LSB = 23;
    localparam int WFC_BUS_RX_NUM = 6;
endpackage : wfc_pkg

//--- hdl/wfc_group.sv
// Module: one group of sticky wake-up factor bits with mask
module wfc_group
    import wfc_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] event_in,
    input wire logic [WIDTH-1:0] clear_in,
    input wire logic mask_we,
    input wire logic [WIDTH-1:0] mask_wdata,
    output logic [WIDTH-1:0] flags_r,
    output logic [WIDTH-1:0] mask_r,
    output logic wake_nxt
);
    logic [WIDTH-1:0] flags_nxt;
    logic [WIDTH-1:0] mask_nxt;

    // Set wins over clear so a late event is kept
    assign flags_nxt = (flags_r & ~clear_in) | event_in; // see R10

    // ----------------------------------------------------------------
    // Factor and mask storage
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            flags_r <= WIDTH'(WFC_FLAGS_RST); // see R1
        else
            flags_r <= flags_nxt; // see R3
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            mask_r <= WIDTH'(WFC_MASK_RST); // see R1
        else if (mask_we)
            mask_r <= mask_wdata; // see R4
    end

    // Next mask too, else wake lags a mask write by one cycle
    assign mask_nxt = mask_we ? mask_wdata : mask_r;

    // Mask bit one blocks the factor, same position as the flag
    assign wake_nxt = |(flags_nxt & ~mask_nxt); // see R9

    a_set_wins: assert property (@(posedge core_clk) disable iff (!nrst)
        event_in[0] |=> flags_r[0]) // see R10
        else $error("event on bit 0 not recorded");
    a_flag_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        flags_r[0] && !clear_in[0] |=> flags_r[0]) // see R10
        else $error("flag bit 0 lost without clear");
    a_clear_works: assert property (@(posedge core_clk) disable iff (!nrst)
        clear_in[2] && !event_in[2] |=> !flags_r[2]) // see R5
        else $error("clear of bit 2 had no effect");
endmodule : wfc_group

//--- verif/wfc_event_src.sv
// Partner model: wake-up event sources as one-cycle pulses
module wfc_event_src
    import wfc_pkg::*;
(
    input wire logic core_clk,
    input wire logic fire,
    input wire logic [1:0] grp,
    input wire logic [4:0] idx,
    input wire logic rx_fire,
    output logic [31:0] ev_low,
    output logic [31:0] ev_mid,
    output logic [31:0] ev_high,
    output logic [WFC_BUS_RX_NUM-1:0] rx
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // Pulses
    // ----------------------------------------------------------------
    // Low again next cycle, so a stuck flag cannot hide behind the event
    initial
    begin
        ev_low = 32'h0;
        ev_mid = 32'h0;
        ev_high = 32'h0;
        rx = '0;
    end
    always @(posedge core_clk)
    begin
        ev_low <= (fire && grp == 2'h0) ? 32'h1 << idx : 32'h0;
        ev_mid <= (fire && grp == 2'h1) ? 32'h1 << idx : 32'h0;
        ev_high <= (fire && grp == 2'h2) ? 32'h1 << idx : 32'h0;
        rx <= rx_fire ? 6'h01 << idx[2:0] : 6'h00;
    end
endmodule : wfc_event_src

//--- verif/wfc_top_test.sv
// Testbench: register access and wake-up factor scenarios
module wfc_top_test
    import wfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, nrst, system_reset, power_up_reset, deep_stop_mode;
    logic psel, penable, pwrite, pready, pslverr, wake_request, er;
    logic fire, rx_fire;
    logic [1:0] grp;
    logic [4:0] idx;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, ev_low, ev_mid, ev_high;
    logic [WFC_BUS_RX_NUM-1:0] rx;
    int num_errors = 0;
    int checks = 0;
    logic [7:0] fo [3] = '{WFC_OFS_FLAGS_LOW, WFC_OFS_FLAGS_MID,
        WFC_OFS_FLAGS_HIGH};
    logic [7:0] mo [3] = '{WFC_OFS_MASK_LOW, WFC_OFS_MASK_MID,
        WFC_OFS_MASK_HIGH};
    logic [7:0] co [3] = '{WFC_OFS_CLEAR_LOW, WFC_OFS_CLEAR_MID,
        WFC_OFS_CLEAR_HIGH};
    // Low bit 7 is an external interrupt input, the serial wake path
    int bits [3][2] = '{'{0, 7}, '{2, 31}, '{0, 14}};
    wfc_top u_dut (.core_clk(core_clk), .nrst(nrst),
        .system_reset(system_reset), .power_up_reset(power_up_reset),
        .deep_stop_mode(deep_stop_mode), .wake_events_low(ev_low),
        .wake_events_mid(ev_mid), .wake_events_high(ev_high),
        .bus_receive_input(rx), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wake_request(wake_request));
    wfc_event_src u_src (.core_clk(core_clk), .fire(fire), .grp(grp),
        .idx(idx), .rx_fire(rx_fire), .ev_low(ev_low), .ev_mid(ev_mid),
        .ev_high(ev_high), .rx(rx));
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task end_sim;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask : chk
    task chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %b got %b", nm, e, g);
            num_errors++;
        end
    endtask : chk_bit
    // Answer taken at the rising edge where pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            num_errors++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd);
        chk_bit("pslverr", 1'b0, er);
    endtask : rd_chk
    task pulse(input logic [1:0] g, input logic [4:0] b, input logic r);
        @(posedge core_clk);
        fire <= !r;
        rx_fire <= r;
        grp <= g;
        idx <= b;
        @(posedge core_clk);
        fire <= 1'b0;
        rx_fire <= 1'b0;
    endtask : pulse
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial
    begin
        {nrst, system_reset, power_up_reset, deep_stop_mode} = 4'h0;
        {psel, penable, pwrite, fire, rx_fire} = 5'h0;
        {grp, idx, paddr, pwdata} = '0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        for (int g = 0; g < 3; g++)
        begin
            rd_chk(fo[g], WFC_FLAGS_RST);
            rd_chk(mo[g], WFC_MASK_RST);
            rd_chk(co[g], 32'h0);
        end
        rd_chk(WFC_OFS_STATUS, 32'h0);
        apb(1'b1, WFC_OFS_FLAGS_LOW, 32'hFFFF_FFFF);
        rd_chk(WFC_OFS_FLAGS_LOW, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk_bit("pslverr", 1'b1, er);
        chk("unmapped", 32'h0, rd);
        for (int g = 0; g < 3; g++)
            for (int j = 0; j < 2; j++)
            begin
                pulse(g[1:0], bits[g][j][4:0], 1'b0);
                rd_chk(fo[g], 32'h1 << bits[g][j]);
                chk_bit("wake_request", 1'b0, wake_request);
                apb(1'b1, mo[g], ~(32'h1 << bits[g][j]));
                rd_chk(WFC_OFS_STATUS, 32'h1);
                chk_bit("wake_request", 1'b1, wake_request);
                apb(1'b1, co[g], 32'h1 << (bits[g][j] ^ 1));
                rd_chk(fo[g], 32'h1 << bits[g][j]);
                apb(1'b1, co[g], 32'h1 << bits[g][j]);
                rd_chk(fo[g], 32'h0);
                rd_chk(WFC_OFS_STATUS, 32'h0);
                apb(1'b1, mo[g], WFC_MASK_RST);
            end
        deep_stop_mode <= 1'b1;
        for (int k = 0; k < WFC_BUS_RX_NUM; k++)
        begin
            pulse(2'h0, k[4:0], 1'b1);
            rd_chk(WFC_OFS_FLAGS_LOW, 32'h1 << (WFC_BUS_RX_LSB + k));
            rd_chk(WFC_OFS_STATUS, 32'h2);
            apb(1'b1, WFC_OFS_CLEAR_LOW, 32'hFFFF_FFFF);
        end
        for (int r = 0; r < 2; r++)
        begin
            pulse(2'h0, 5'h03, 1'b0);
            apb(1'b1, WFC_OFS_MASK_LOW, 32'h0);
            @(posedge core_clk);
            system_reset <= (r == 0);
            power_up_reset <= (r == 1);
            @(posedge core_clk);
            {system_reset, power_up_reset} <= 2'h0;
            rd_chk(WFC_OFS_FLAGS_LOW, WFC_FLAGS_RST);
            rd_chk(WFC_OFS_MASK_LOW, WFC_MASK_RST);
            chk_bit("wake_request", 1'b0, wake_request);
        end
        end_sim();
    end
endmodule : wfc_top_test
